// File: rbr_top.sv
// Remote buffer read sequencer: register file, issue, link arbitration,
// destination memory, end-of-scan completion flags and interrupt.
// Assumes link, remote bit image and scan strobe share the system clock.
//
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
module rbr_top (
  input wire logic clock, // System clock, 100 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [12:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte enables
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output rbr_pkg::rbr_link_cmd_t link_cmd, // Link command
  output logic link_cmd_valid, // Link command valid
  input wire logic link_cmd_ready, // Link command taken
  input wire logic link_data_valid, // Fetched word strobe
  input wire logic [15:0] link_data, // Fetched word
  output logic [rbr_pkg::NENG-1:0][6:0] remote_in_station, // Station of watched bit
  output logic [rbr_pkg::NENG-1:0][6:0] remote_in_bit, // Watched input bit number
  input wire logic [rbr_pkg::NENG-1:0] remote_in_level, // Watched input level
  output logic [rbr_pkg::NENG-1:0] remote_ack_output, // Acknowledge level
  output logic [rbr_pkg::NENG-1:0][6:0] remote_ack_station, // Station of ack bit
  output logic [rbr_pkg::NENG-1:0][6:0] remote_ack_bit, // Acknowledge bit number
  input wire logic end_of_scan, // Pulse: end-of-scan processing
  output logic [rbr_pkg::NENG-1:0] done_flag, // Completion flags
  output logic [rbr_pkg::NENG-1:0] error_flag, // Error flags
  output logic irq // Level interrupt
);
  import rbr_pkg::*;

  localparam int IRQ_W = NENG + 1;

  logic [6:0] station_reg;
  logic [15:0] attr_reg;
  logic [15:0] buf_addr_reg;
  logic [8:0] points_reg;
  logic [6:0] ack_bit_reg;
  logic [6:0] rdy_bit_reg;
  logic [8:0] dest_reg;
  logic [15:0] monitor_time_setting;
  logic [15:0] retry_count_setting;
  logic [NENG-1:0][15:0] status_word;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [NENG-1:0] pend_done;
  logic [NENG-1:0] pend_err;
  logic [15:0] dest_mem [0:511];

  logic bus_ack;
  logic wr_take;
  logic issue_q;
  logic [15:0] be_data;
  logic [NENG-1:0] eng_start;
  logic [NENG-1:0] eng_busy;
  logic [NENG-1:0] eng_fetching;
  logic [NENG-1:0][6:0] eng_station;
  rbr_link_cmd_t eng_cmd [NENG];
  logic [NENG-1:0] eng_cmd_valid;
  logic [NENG-1:0] eng_cmd_ready;
  logic [NENG-1:0] eng_data_valid;
  rbr_mem_wr_t eng_mem_wr [NENG];
  logic [NENG-1:0] eng_done;
  logic [NENG-1:0] eng_done_err;
  logic [15:0] eng_done_code [NENG];
  logic station_clash;
  logic any_free;
  logic drop_evt;
  logic fetch_lock;
  logic [$clog2(NENG)-1:0] fetch_owner;
  logic [$clog2(NENG)-1:0] sel;
  logic sel_any;
  rbr_op_t new_op;
  rbr_mem_wr_t mem_port;

  // One wait state on every access, then the answer
  assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;
  assign wr_take = avs_write && bus_ack;
  assign be_data = {avs_byteenable[1] ? avs_writedata[15:8] : 8'h00,
                    avs_byteenable[0] ? avs_writedata[7:0] : 8'h00};

  always_ff @(posedge clock) begin
    if (rst) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (avs_read || avs_write) && !bus_ack;
    end
  end

  // Settings and control words
  always_ff @(posedge clock) begin
    if (rst) begin
      station_reg <= 7'h00;
      attr_reg <= RST_ATTR;
      buf_addr_reg <= 16'h0000;
      points_reg <= 9'h000;
      ack_bit_reg <= 7'h00;
      rdy_bit_reg <= 7'h00;
      dest_reg <= 9'h000;
      monitor_time_setting <= RST_MON_TIME;
      retry_count_setting <= RST_RETRY;
      irq_mask <= '0;
    end else if (wr_take) begin
      case (avs_address)
        OFS_STATION: station_reg <= be_data[6:0];
        OFS_ATTR: attr_reg <= be_data;
        OFS_BUF_ADDR: buf_addr_reg <= be_data;
        OFS_POINTS: points_reg <= be_data[8:0];
        OFS_ACK_BIT: ack_bit_reg <= be_data[6:0];
        OFS_RDY_BIT: rdy_bit_reg <= be_data[6:0];
        OFS_DEST: dest_reg <= be_data[8:0];
        OFS_MON_TIME: monitor_time_setting <= be_data;
        OFS_RETRY: retry_count_setting <= be_data;
        OFS_IRQ_MASK: irq_mask <= be_data[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Issue strobe, decided one cycle after the write
  always_ff @(posedge clock) begin
    if (rst) begin
      issue_q <= 1'b0;
    end else begin
      issue_q <= wr_take && (avs_address == OFS_CMD) && avs_byteenable[0] && avs_writedata[0];
    end
  end

  assign new_op.station = station_reg;
  assign new_op.buf_addr = buf_addr_reg;
  assign new_op.points = points_reg;
  assign new_op.ack_bit = ack_bit_reg;
  assign new_op.rdy_bit = rdy_bit_reg;
  assign new_op.dest = dest_reg;

  // pick a free engine, drop on clash
  always_comb begin
    station_clash = 1'b0;
    any_free = 1'b0;
    eng_start = '0;
    for (int e = 0; e < NENG; e++) begin
      if (eng_busy[e] && eng_station[e] == station_reg) begin
        station_clash = 1'b1;
      end
    end
    for (int e = 0; e < NENG; e++) begin
      if (!eng_busy[e] && !any_free) begin
        any_free = 1'b1;
        eng_start[e] = issue_q && !station_clash;
      end
    end
  end

  assign drop_evt = issue_q && (station_clash || !any_free);

  // Link arbitration; a fetch holds the link until its words are in
  always_comb begin
    sel = '0;
    sel_any = 1'b0;
    for (int e = NENG - 1; e >= 0; e--) begin
      if (eng_cmd_valid[e]) begin
        sel = ($clog2(NENG))'(e);
        sel_any = 1'b1;
      end
    end
  end

  assign link_cmd_valid = sel_any && !fetch_lock;
  assign link_cmd = eng_cmd[sel];

  always_comb begin
    eng_cmd_ready = '0;
    eng_data_valid = '0;
    eng_cmd_ready[sel] = link_cmd_ready && link_cmd_valid;
    eng_data_valid[fetch_owner] = link_data_valid && fetch_lock;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      fetch_lock <= 1'b0;
      fetch_owner <= '0;
    end else if (fetch_lock) begin
      if (!eng_fetching[fetch_owner]) begin
        fetch_lock <= 1'b0;
      end
    end else if (link_cmd_valid && link_cmd_ready && link_cmd.kind == RBR_CMD_FETCH) begin
      fetch_lock <= 1'b1;
      fetch_owner <= sel;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NENG; g++) begin : gen_eng
      rbr_engine u_eng (
        .clock(clock),
        .rst(rst),
        .start(eng_start[g]),
        .op_in(new_op),
        .mon_time(monitor_time_setting),
        .retries(retry_count_setting),
        .busy(eng_busy[g]),
        .fetching(eng_fetching[g]),
        .station(eng_station[g]),
        .cmd(eng_cmd[g]),
        .cmd_valid(eng_cmd_valid[g]),
        .cmd_ready(eng_cmd_ready[g]),
        .data_valid(eng_data_valid[g]),
        .data(link_data),
        .mem_wr(eng_mem_wr[g]),
        .rdy_bit(remote_in_bit[g]),
        .rdy_level(remote_in_level[g]),
        .ack_out(remote_ack_output[g]),
        .ack_bit(remote_ack_bit[g]),
        .done(eng_done[g]),
        .done_err(eng_done_err[g]),
        .done_code(eng_done_code[g])
      );
      assign remote_in_station[g] = eng_station[g];
      assign remote_ack_station[g] = eng_station[g];
    end
  endgenerate

  // Only the fetch owner writes, so the ports never collide
  always_comb begin
    mem_port = '0;
    for (int e = 0; e < NENG; e++) begin
      if (eng_mem_wr[e].wr) begin
        mem_port = eng_mem_wr[e];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (mem_port.wr) begin
      dest_mem[mem_port.addr] <= mem_port.data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      status_word <= '0;
    end else begin
      for (int e = 0; e < NENG; e++) begin
        if (eng_done[e]) begin
          status_word[e] <= eng_done_code[e];
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pend_done <= '0;
      pend_err <= '0;
      done_flag <= '0;
      error_flag <= '0;
    end else begin
      for (int e = 0; e < NENG; e++) begin
        if (end_of_scan) begin
          done_flag[e] <= pend_done[e] || eng_done[e];
          error_flag[e] <= (pend_done[e] && pend_err[e]) || (eng_done[e] && eng_done_err[e]);
          pend_done[e] <= 1'b0;
          pend_err[e] <= 1'b0;
        end else if (eng_done[e]) begin
          pend_done[e] <= 1'b1;
          pend_err[e] <= eng_done_err[e];
        end
      end
    end
  end

  // Sticky events, set wins over a write-one clear
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~((wr_take && avs_address == OFS_IRQ_STAT) ?
                   be_data[IRQ_W-1:0] : {IRQ_W{1'b0}})) | {drop_evt, eng_done};
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // Read data latched during the wait state
  always_ff @(posedge clock) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !bus_ack) begin
      if (avs_address >= OFS_MEM) begin
        avs_readdata <= {16'h0000, dest_mem[avs_address[10:2]]};
      end else begin
        case (avs_address)
          OFS_STATION: avs_readdata <= {25'h0000000, station_reg};
          OFS_ATTR: avs_readdata <= {16'h0000, attr_reg};
          OFS_BUF_ADDR: avs_readdata <= {16'h0000, buf_addr_reg};
          OFS_POINTS: avs_readdata <= {23'h000000, points_reg};
          OFS_ACK_BIT: avs_readdata <= {25'h0000000, ack_bit_reg};
          OFS_RDY_BIT: avs_readdata <= {25'h0000000, rdy_bit_reg};
          OFS_DEST: avs_readdata <= {23'h000000, dest_reg};
          OFS_MON_TIME: avs_readdata <= {16'h0000, monitor_time_setting};
          OFS_RETRY: avs_readdata <= {16'h0000, retry_count_setting};
          OFS_STATUS0: avs_readdata <= {16'h0000, status_word[0]};
          OFS_STATUS1: avs_readdata <= {16'h0000, status_word[1]};
          OFS_FLAGS: avs_readdata <= {26'h0000000, eng_busy, error_flag, done_flag};
          OFS_IRQ_STAT: avs_readdata <= {29'h00000000, irq_stat};
          OFS_IRQ_MASK: avs_readdata <= {29'h00000000, irq_mask};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// File: rbr_pkg.sv
// Shared constants and types for the remote buffer read sequencer.
// Assumes a single 100 MHz clock and a 32-bit Avalon-MM register bus.
package rbr_pkg;

  localparam int NENG = 2;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MON_UNIT_NS = 1000;
  localparam int MON_UNIT_CYC = (MON_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [12:0] OFS_CMD = 13'h000;
  localparam logic [12:0] OFS_STATION = 13'h004;
  localparam logic [12:0] OFS_ATTR = 13'h008;
  localparam logic [12:0] OFS_BUF_ADDR = 13'h00c;
  localparam logic [12:0] OFS_POINTS = 13'h010;
  localparam logic [12:0] OFS_ACK_BIT = 13'h014;
  localparam logic [12:0] OFS_RDY_BIT = 13'h018;
  localparam logic [12:0] OFS_DEST = 13'h01c;
  localparam logic [12:0] OFS_MON_TIME = 13'h020;
  localparam logic [12:0] OFS_RETRY = 13'h024;
  localparam logic [12:0] OFS_STATUS0 = 13'h028;
  localparam logic [12:0] OFS_STATUS1 = 13'h02c;
  localparam logic [12:0] OFS_FLAGS = 13'h030;
  localparam logic [12:0] OFS_IRQ_STAT = 13'h034;
  localparam logic [12:0] OFS_IRQ_MASK = 13'h038;
  localparam logic [12:0] OFS_MEM = 13'h800;

  localparam logic [15:0] RST_ATTR = 16'h0004;
  localparam logic [15:0] RST_MON_TIME = 16'h0064;
  localparam logic [15:0] RST_RETRY = 16'h0003;
  localparam logic [15:0] STATUS_OK = 16'h0000;
  localparam logic [15:0] ERR_TIMEOUT = 16'hb001;
  localparam logic [15:0] ERR_PARAM = 16'hb002;
  localparam logic [6:0] MIN_STATION = 7'h01;
  localparam logic [6:0] MAX_STATION = 7'h40;
  localparam logic [8:0] MAX_POINTS = 9'h1e0;

  typedef enum logic {
    RBR_CMD_REQUEST = 1'b0,
    RBR_CMD_FETCH = 1'b1
  } rbr_kind_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_REQ = 6'b000010,
    ST_WAIT = 6'b000100,
    ST_FETCH = 6'b001000,
    ST_ACK = 6'b010000,
    ST_DONE = 6'b100000
  } rbr_state_t;

  typedef struct packed {
    logic [6:0] station;
    logic [15:0] buf_addr;
    logic [8:0] points;
    logic [6:0] ack_bit;
    logic [6:0] rdy_bit;
    logic [8:0] dest;
  } rbr_op_t;

  typedef struct packed {
    rbr_kind_t kind;
    logic [6:0] station;
    logic [15:0] buf_addr;
    logic [8:0] points;
  } rbr_link_cmd_t;

  typedef struct packed {
    logic wr;
    logic [8:0] addr;
    logic [15:0] data;
  } rbr_mem_wr_t;

endpackage

// File: rbr_engine.sv
// One read sequencer: request, ready watch, fetch, acknowledge, finish.
// Assumes the link, remote bit image and memory port are on the same clock.
`timescale 1ns/10ps
module rbr_engine (
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic start, // Pulse: take op_in
  input rbr_pkg::rbr_op_t op_in, // Operation parameters
  input wire logic [15:0] mon_time, // Supervision time, units
  input wire logic [15:0] retries, // Retry limit
  output logic busy, // Operation in progress
  output logic fetching, // In fetch phase
  output logic [6:0] station, // Station of current op
  output rbr_pkg::rbr_link_cmd_t cmd, // Link command
  output logic cmd_valid, // Link command valid
  input wire logic cmd_ready, // Link command taken
  input wire logic data_valid, // Fetched word strobe
  input wire logic [15:0] data, // Fetched word
  output rbr_pkg::rbr_mem_wr_t mem_wr, // Destination write
  output logic [6:0] rdy_bit, // Watched input bit number
  input wire logic rdy_level, // Watched input bit level
  output logic ack_out, // Acknowledge output level
  output logic [6:0] ack_bit, // Acknowledge bit number
  output logic done, // Pulse: operation finished
  output logic done_err, // Finished with error
  output logic [15:0] done_code // Completion status
);
  import rbr_pkg::*;

  rbr_state_t state;
  rbr_op_t op;
  logic [15:0] tries;
  logic [8:0] word_cnt;
  logic fetch_sent;
  logic [$clog2(MON_UNIT_CYC)-1:0] pre_cnt;
  logic [15:0] unit_cnt;
  logic timed_out;
  logic param_bad;

  assign param_bad = (op_in.station < MIN_STATION) || (op_in.station > MAX_STATION) ||
                     (op_in.points == 9'h000) || (op_in.points > MAX_POINTS);
  assign timed_out = (unit_cnt >= mon_time);

  // supervision timer
  // Held clear while fetching, so a long fetch leaves the ack phase its full time
  always_ff @(posedge clock) begin
    if (rst || state == ST_REQ || state == ST_IDLE || state == ST_FETCH) begin
      pre_cnt <= '0;
      unit_cnt <= 16'h0000;
    end else if (pre_cnt == ($clog2(MON_UNIT_CYC))'(MON_UNIT_CYC - 1)) begin
      pre_cnt <= '0;
      if (!timed_out) begin
        unit_cnt <= unit_cnt + 16'h0001;
      end
    end else begin
      pre_cnt <= pre_cnt + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ST_IDLE;
      op <= '0;
      tries <= 16'h0000;
      word_cnt <= 9'h000;
      fetch_sent <= 1'b0;
      done_err <= 1'b0;
      done_code <= STATUS_OK;
      mem_wr <= '0;
    end else begin
      mem_wr.wr <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start) begin
            op <= op_in;
            tries <= 16'h0000;
            word_cnt <= 9'h000;
            fetch_sent <= 1'b0;
            if (param_bad) begin
              done_err <= 1'b1;
              done_code <= ERR_PARAM;
              state <= ST_DONE;
            end else begin
              state <= ST_REQ;
            end
          end
        end
        ST_REQ: begin
          if (cmd_ready) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (rdy_level) begin
            state <= ST_FETCH;
          end else if (timed_out) begin
            if (tries < retries) begin
              tries <= tries + 16'h0001;
              state <= ST_REQ;
            end else begin
              done_err <= 1'b1;
              done_code <= ERR_TIMEOUT;
              state <= ST_DONE;
            end
          end
        end
        ST_FETCH: begin
          if (cmd_valid && cmd_ready) begin
            fetch_sent <= 1'b1;
          end
          if (fetch_sent && data_valid) begin
            mem_wr.wr <= 1'b1;
            mem_wr.addr <= op.dest + word_cnt;
            mem_wr.data <= data;
            word_cnt <= word_cnt + 9'h001;
            if (word_cnt == op.points - 9'h001) begin
              state <= ST_ACK;
            end
          end
        end
        ST_ACK: begin
          if (!rdy_level) begin
            done_err <= 1'b0;
            done_code <= STATUS_OK;
            state <= ST_DONE;
          end else if (timed_out) begin
            done_err <= 1'b1;
            done_code <= ERR_TIMEOUT;
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign busy = (state != ST_IDLE);
  assign fetching = (state == ST_FETCH);
  assign done = (state == ST_DONE);
  assign station = op.station;
  assign rdy_bit = op.rdy_bit;
  assign ack_bit = op.ack_bit;
  assign ack_out = (state == ST_ACK);
  assign cmd_valid = (state == ST_REQ) || (state == ST_FETCH && !fetch_sent);
  assign cmd.kind = (state == ST_FETCH) ? RBR_CMD_FETCH : RBR_CMD_REQUEST;
  assign cmd.station = op.station;
  assign cmd.buf_addr = op.buf_addr;
  assign cmd.points = op.points;

endmodule

// File: rbr_top_props.sv
// Concurrent checks on the ports of the remote buffer read sequencer.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module rbr_top_props (
  input wire logic clock, // System clock
  input wire logic rst, // Reset
  input wire logic avs_read, // Bus read
  input wire logic avs_write, // Bus write
  input wire logic avs_waitrequest, // Bus stall
  input wire rbr_pkg::rbr_link_cmd_t link_cmd, // Link command
  input wire logic link_cmd_valid, // Command valid
  input wire logic link_cmd_ready, // Command taken
  input wire logic link_data_valid, // Word strobe
  input wire logic [rbr_pkg::NENG-1:0] remote_in_level, // Ready levels
  input wire logic [rbr_pkg::NENG-1:0] remote_ack_output, // Ack levels
  input wire logic end_of_scan, // Scan end pulse
  input wire logic [rbr_pkg::NENG-1:0] done_flag, // Completion flags
  input wire logic [rbr_pkg::NENG-1:0] error_flag // Error flags
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_bus_one_wait: assert property (
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("bus wait not one cycle");
  a_cmd_held: assert property (
    link_cmd_valid && !link_cmd_ready |=> link_cmd_valid && $stable(link_cmd)) else $error("link command dropped");
  a_ack_after_word: assert property (
    $rose(remote_ack_output[0]) |-> $past(link_data_valid)) else $error("ack without fetched word");
  a_ack_release: assert property (
    remote_ack_output[0] && !remote_in_level[0] |=> !remote_ack_output[0]) else $error("ack held after ready low");
  a_done_at_scan: assert property (
    $changed(done_flag[0]) |-> $past(end_of_scan)) else $error("done flag moved off scan end");
  a_done_one_scan: assert property (
    done_flag[0] && end_of_scan |=> !done_flag[0]) else $error("done flag longer than one scan");
  a_err_at_scan: assert property (
    $changed(error_flag[0]) |-> $past(end_of_scan)) else $error("error flag moved off scan end");
  a_err_with_done: assert property (
    error_flag[0] |-> done_flag[0]) else $error("error flag without done flag");
endmodule
bind rbr_top rbr_top_props u_props (.clock(clock), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .link_cmd(link_cmd), .link_cmd_valid(link_cmd_valid),
  .link_cmd_ready(link_cmd_ready), .link_data_valid(link_data_valid), .remote_in_level(remote_in_level),
  .remote_ack_output(remote_ack_output), .end_of_scan(end_of_scan), .done_flag(done_flag), .error_flag(error_flag));

// File: rbr_station_model.sv
// Link slave and remote stations; a station's ready bit is its own number, ack bit number plus one.
// Assumes the same clock as the sequencer; station 64 never answers.
`timescale 1ns/10ps
module rbr_station_model import rbr_pkg::*; (
  input wire logic clock, // System clock
  input wire logic rst, // Reset
  input rbr_link_cmd_t link_cmd, // Command
  input wire logic link_cmd_valid, // Command valid
  output logic link_cmd_ready, // Command taken
  output logic link_data_valid, // Word strobe
  output logic [15:0] link_data, // Word
  input wire logic [NENG-1:0][6:0] remote_in_station, // Watched station
  input wire logic [NENG-1:0][6:0] remote_in_bit, // Watched bit
  output logic [NENG-1:0] remote_in_level, // Ready levels
  input wire logic [NENG-1:0] remote_ack_output, // Ack levels
  input wire logic [NENG-1:0][6:0] remote_ack_station, // Ack station
  input wire logic [NENG-1:0][6:0] remote_ack_bit, // Ack bit
  output logic [7:0] n_req // Requests to silent station
);
  logic [127:0] armed;
  logic [8:0] left;
  logic [15:0] waddr;
  logic phase;
  always_ff @(posedge clock) begin
    if (rst) begin
      armed <= '0;
      n_req <= 8'h00;
      left <= 9'h000;
      waddr <= 16'h0000;
      phase <= 1'b0;
      link_cmd_ready <= 1'b0;
      link_data_valid <= 1'b0;
      link_data <= 16'h0000;
    end else begin
      // Half-rate ready and words: a slow partner
      link_cmd_ready <= !link_cmd_ready;
      phase <= !phase;
      link_data_valid <= 1'b0;
      link_data <= ~link_data;
      if (link_cmd_valid && link_cmd_ready) begin
        if (link_cmd.kind == RBR_CMD_FETCH) begin
          left <= link_cmd.points;
          waddr <= link_cmd.buf_addr;
        end else if (link_cmd.station == 7'h40) begin
          n_req <= n_req + 8'h01;
        end else begin
          armed[link_cmd.station] <= 1'b1;
        end
      end else if (left != 9'h000 && phase) begin
        link_data_valid <= 1'b1;
        link_data <= waddr;
        waddr <= waddr + 16'h0001;
        left <= left - 9'h001;
      end
      for (int e = 0; e < NENG; e++) begin
        if (remote_ack_output[e] && remote_ack_bit[e] == remote_ack_station[e] + 7'h01) begin
          armed[remote_ack_station[e]] <= 1'b0;
        end
      end
    end
  end
  always_comb begin
    for (int e = 0; e < NENG; e++) begin
      remote_in_level[e] = armed[remote_in_station[e]] && (remote_in_bit[e] == remote_in_station[e]);
    end
  end
endmodule

// File: tb_rbr_top.sv
// Bench for the remote buffer read sequencer over its register bus.
// Assumes the station model answers in place of the remote stations.
`timescale 1ns/10ps
module tb_rbr_top;
  import rbr_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [12:0] avs_address = 13'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, link_cmd_valid, link_cmd_ready, link_data_valid, irq;
  logic end_of_scan = 1'b0;
  rbr_link_cmd_t link_cmd;
  logic [15:0] link_data;
  logic [NENG-1:0][6:0] in_st, in_bit, ack_st, ack_bit;
  logic [NENG-1:0] in_lvl, ack_o, done_flag, error_flag;
  logic [7:0] n_req;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [12:0] ofs[5] = '{OFS_ATTR, OFS_MON_TIME, OFS_RETRY, 13'h040, OFS_FLAGS};
  logic [15:0] rv[5] = '{RST_ATTR, RST_MON_TIME, RST_RETRY, 16'h0000, 16'h0000};
  logic [6:0] bad_st[4] = '{7'h00, 7'h41, 7'h05, 7'h05};
  logic [8:0] bad_pt[4] = '{9'h001, 9'h001, 9'h000, 9'h1e1};
  rbr_top DUT (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link_cmd(link_cmd), .link_cmd_valid(link_cmd_valid),
    .link_cmd_ready(link_cmd_ready), .link_data_valid(link_data_valid), .link_data(link_data),
    .remote_in_station(in_st), .remote_in_bit(in_bit), .remote_in_level(in_lvl), .remote_ack_output(ack_o),
    .remote_ack_station(ack_st), .remote_ack_bit(ack_bit), .end_of_scan(end_of_scan), .done_flag(done_flag),
    .error_flag(error_flag), .irq(irq));
  rbr_station_model u_station (.clock(clock), .rst(rst), .link_cmd(link_cmd), .link_cmd_valid(link_cmd_valid),
    .link_cmd_ready(link_cmd_ready), .link_data_valid(link_data_valid), .link_data(link_data),
    .remote_in_station(in_st), .remote_in_bit(in_bit), .remote_in_level(in_lvl), .remote_ack_output(ack_o),
    .remote_ack_station(ack_st), .remote_ack_bit(ack_bit), .n_req(n_req));
  initial begin
    forever #5 clock = ~clock;
  end
  // Scan every 40 cycles; watchdog well above the run length
  always @(posedge clock) begin
    cyc <= cyc + 1;
    end_of_scan <= (cyc % 40 == 39);
    if (cyc == 20000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [12:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask
  // Ready bit is the station number, ack bit one above, both under 80 hex
  task automatic issue(input logic [6:0] s, input logic [15:0] ba, input logic [8:0] pts, input logic [8:0] dst);
    bus(1'b1, OFS_STATION, {25'h0, s});
    bus(1'b1, OFS_BUF_ADDR, {16'h0, ba});
    bus(1'b1, OFS_POINTS, {23'h0, pts});
    bus(1'b1, OFS_ACK_BIT, {25'h0, s + 7'h01});
    bus(1'b1, OFS_RDY_BIT, {25'h0, s});
    bus(1'b1, OFS_DEST, {23'h0, dst});
    bus(1'b1, OFS_CMD, 32'h1);
  endtask
  // Waits until the masked flags have pulsed and fallen again
  task automatic wait_done(input logic [1:0] m, output logic [1:0] e);
    logic [1:0] g;
    g = 2'b00;
    e = 2'b00;
    do begin
      @(posedge clock);
      g = g | done_flag;
      e = e | (error_flag & m);
    end while ((g & m) != m || (done_flag & m) != 2'b00);
  endtask
  task automatic conclude();
    $display("Checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    logic [8:0] idx;
    logic [1:0] e;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ofs[i], 32'h0);
      check(rd, {16'h0, rv[i]});
    end
    bus(1'b1, OFS_MON_TIME, 32'h1);
    bus(1'b1, OFS_RETRY, 32'h1);
    bus(1'b0, OFS_MON_TIME, 32'h0);
    check(rd, 32'h1);
    // Destination wraps past the top of the area
    issue(7'h05, 16'h0100, 9'h004, 9'h1fe);
    wait_done(2'b01, e);
    check({30'h0, e}, 32'h0);
    bus(1'b0, OFS_STATUS0, 32'h0);
    check(rd, {16'h0, STATUS_OK});
    for (int i = 0; i < 4; i++) begin
      idx = 9'h1fe + 9'(i);
      bus(1'b0, OFS_MEM + {2'b00, idx, 2'b00}, 32'h0);
      check(rd, {16'h0, 16'h0100 + 16'(i)});
    end
    bus(1'b1, OFS_IRQ_STAT, 32'h7);
    issue(7'h06, 16'h0200, 9'h1e0, 9'h000);
    issue(7'h07, 16'h0300, 9'h001, 9'h1f0);
    bus(1'b0, OFS_FLAGS, 32'h0);
    check(rd & 32'h30, 32'h30);
    issue(7'h06, 16'h0400, 9'h001, 9'h000);
    wait_done(2'b11, e);
    check({30'h0, e}, 32'h0);
    bus(1'b0, OFS_MEM, 32'h0);
    check(rd, 32'h0200);
    bus(1'b0, OFS_MEM + 13'h77c, 32'h0);
    check(rd, 32'h03df);
    bus(1'b0, OFS_MEM + 13'h7c0, 32'h0);
    check(rd, 32'h0300);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    check(rd, 32'h7);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, OFS_IRQ_MASK, 32'h4);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, OFS_IRQ_STAT, 32'h7);
    check({31'h0, irq}, 32'h0);
    issue(7'h40, 16'h0000, 9'h001, 9'h000);
    wait_done(2'b01, e);
    check({30'h0, e}, 32'h1);
    check({24'h0, n_req}, 32'h2);
    bus(1'b0, OFS_STATUS0, 32'h0);
    check(rd, {16'h0, ERR_TIMEOUT});
    for (int i = 0; i < 4; i++) begin
      issue(bad_st[i], 16'h0000, bad_pt[i], 9'h000);
      wait_done(2'b01, e);
      check({30'h0, e}, 32'h1);
      bus(1'b0, OFS_STATUS0, 32'h0);
      check(rd, {16'h0, ERR_PARAM});
    end
    conclude();
  end
endmodule
